// File: logic/vrs_detect.sv
// Design: digital control of the reluctance/Hall crank-sensor input channel
`timescale 1ns/1ps
// Overview of operation
// - Reluctance modes: pulse output toggles on differential zero crossings, both edges.
// - Next zero crossing armed only after a peak (slope sign reversal).
// - Peak valid only if magnitude exceeded threshold longer than minimum peak time.
// - Pulse output changes only after crossing result stable beyond filter time.
// - Two-bit field selects one of four peak thresholds.
// - One bit selects one of two minimum peak times.
// - Two-bit field selects one of four output filter times.
// - Mode field selects auto, manual, semi-auto or Hall detection.
// - Auto adapts peak time to speed, threshold to previous peaks; semi simpler.
// - Auto, semi-auto and Hall ignore writes of threshold and peak time.
// - Filter time stays under host control in automatic modes.
// - Manual mode uses only host-written threshold, peak time and filter.
// - Hall mode uses hysteretic comparator on first input; diagnosis disabled.
// - Hall mode ignores diagnosis mode, current settings and start command.
// - Three diagnosis modes: short, open load, voltage measurement.
// - Host selects diagnosis mode then starts; device begins measurement then.
// - Active diagnosis enables pull-up on first, pull-down on second input.
// - Each diagnosis signals completion through its own data-valid bit.
// - Short, open-load flags and measured value reported with results.
// - Data-valid clears on restart of its diagnosis or on register read.
// - Reset selects lowest threshold and shortest peak time.
module vrs_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [vrs_pkg::ADC_W-1:0] sensor_diff_sample,
  input wire logic hall_comp_in,
  input wire logic short_ground_comp,
  input wire logic short_battery_comp,
  input wire logic open_load_comp,
  input wire logic cfg_write,
  input wire logic [1:0] peak_threshold_sel,
  input wire logic peak_time_sel,
  input wire logic [1:0] output_filter_sel,
  input wire vrs_pkg::vrs_mode_t detect_mode_sel,
  input wire vrs_pkg::vrs_diag_t diag_mode_sel,
  input wire logic [1:0] short_diag_current_sel,
  input wire logic [1:0] openload_diag_current_sel,
  input wire logic [1:0] measure_diag_current_sel,
  input wire logic diag_start_cmd,
  input wire logic diag_result_a_read,
  input wire logic diag_result_b_read,
  output logic sensor_pulse_out,
  output logic pullup_pos_en,
  output logic pulldown_neg_en,
  output logic [1:0] diag_current_out,
  output logic hall_ref_force,
  output logic [1:0] active_threshold_sel,
  output logic active_time_sel,
  output logic short_diag_valid,
  output logic openload_diag_valid,
  output logic measure_diag_valid,
  output logic short_ground_flag,
  output logic short_battery_flag,
  output logic open_load_flag,
  output logic [vrs_pkg::ADC_W-1:0] measured_voltage_value
);
  import vrs_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [ADC_W-1:0] samp_s1_reg, samp_s2_reg;
  logic [3:0] cmp_s1_reg, cmp_s2_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {samp_s1_reg, samp_s2_reg, cmp_s1_reg, cmp_s2_reg} <= '0;
    end else begin
      samp_s1_reg <= sensor_diff_sample;
      samp_s2_reg <= samp_s1_reg;
      cmp_s1_reg <= {hall_comp_in, short_ground_comp, short_battery_comp, open_load_comp};
      cmp_s2_reg <= cmp_s1_reg;
    end
  end
  logic signed [ADC_W-1:0] samp;
  logic [ADC_W-1:0] mag;
  assign samp = signed'(samp_s2_reg);
  assign mag = samp[ADC_W-1] ? ADC_W'(-samp) : ADC_W'(samp);

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  logic [1:0] thr_reg, thr_next, filt_reg, filt_next;
  logic time_reg, time_next;
  logic auto_mode;
  assign auto_mode = (detect_mode_sel != VRS_MANUAL);
  always_comb begin
    thr_next = thr_reg;
    time_next = time_reg;
    filt_next = filt_reg;
    if (cfg_write) begin
      filt_next = output_filter_sel;
      if (!auto_mode) begin
        thr_next = peak_threshold_sel;
        time_next = peak_time_sel;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {thr_reg, time_reg, filt_reg} <= {PEAK_THR_RST, PEAK_TIME_RST, FILT_RST};
    end else begin
      {thr_reg, time_reg, filt_reg} <= {thr_next, time_next, filt_next};
    end
  end

  // ----------------------------------------------------------------
  // Peak detection and adaptation
  // ----------------------------------------------------------------
  logic [ADC_W-1:0] prev_reg, prev_next, peak_max_reg, peak_max_next;
  logic [1:0] adapt_thr_reg, adapt_thr_next;
  logic adapt_time_reg, adapt_time_next;
  logic rising_reg, rising_next, armed_reg, armed_next, sign_reg, sign_next, zc_reg, zc_next;
  logic [CNT_W-1:0] above_reg, above_next, half_reg, half_next;
  logic [1:0] eff_thr;
  logic eff_time;
  logic [ADC_W-1:0] thr_val;
  logic [CNT_W-1:0] peak_cyc;
  logic above, slope_up, slope_dn, peak_ok;
  assign eff_thr = auto_mode ? adapt_thr_reg : thr_reg;
  assign eff_time = auto_mode ? adapt_time_reg : time_reg;
  assign thr_val = (eff_thr == 2'h0) ? PEAK_THR_0 : (eff_thr == 2'h1) ? PEAK_THR_1 :
                   (eff_thr == 2'h2) ? PEAK_THR_2 : PEAK_THR_3;
  assign peak_cyc = eff_time ? CNT_W'(PEAK_CYC_1) : CNT_W'(PEAK_CYC_0);
  assign above = (mag > thr_val);
  assign slope_up = (samp > signed'(prev_reg));
  assign slope_dn = (samp < signed'(prev_reg));
  assign peak_ok = (above_reg > peak_cyc) && ((rising_reg && slope_dn) || (!rising_reg && slope_up));
  always_comb begin
    prev_next = samp_s2_reg;
    rising_next = slope_up ? 1'b1 : (slope_dn ? 1'b0 : rising_reg);
    above_next = above ? ((above_reg == '1) ? above_reg : above_reg + 1'b1) : '0;
    armed_next = armed_reg;
    sign_next = samp[ADC_W-1];
    zc_next = zc_reg;
    half_next = (half_reg == '1) ? half_reg : half_reg + 1'b1;
    peak_max_next = (above && mag > peak_max_reg) ? mag : peak_max_reg;
    adapt_thr_next = adapt_thr_reg;
    adapt_time_next = adapt_time_reg;
    if (peak_ok) begin
      armed_next = 1'b1;
    end
    if (armed_reg && (sign_reg != samp[ADC_W-1])) begin
      zc_next = ~zc_reg;
      armed_next = 1'b0;
      half_next = '0;
      peak_max_next = '0;
      // Time from speed; threshold from peaks (auto only)
      adapt_time_next = (half_reg > SLOW_HALF_CYC);
      if (detect_mode_sel == VRS_AUTO) begin
        adapt_thr_next = (peak_max_reg > (PEAK_THR_3 << 1)) ? 2'h3 :
                         (peak_max_reg > (PEAK_THR_2 << 1)) ? 2'h2 :
                         (peak_max_reg > (PEAK_THR_1 << 1)) ? 2'h1 : 2'h0;
      end else begin
        adapt_thr_next = 2'h0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {prev_reg, rising_reg, above_reg, armed_reg, sign_reg, zc_reg, half_reg, peak_max_reg} <= '0;
      adapt_thr_reg <= PEAK_THR_RST;
      adapt_time_reg <= PEAK_TIME_RST;
    end else begin
      {prev_reg, rising_reg, above_reg} <= {prev_next, rising_next, above_next};
      {armed_reg, sign_reg, zc_reg} <= {armed_next, sign_next, zc_next};
      {half_reg, peak_max_reg} <= {half_next, peak_max_next};
      {adapt_thr_reg, adapt_time_reg} <= {adapt_thr_next, adapt_time_next};
    end
  end

  // ----------------------------------------------------------------
  // Output filter
  // ----------------------------------------------------------------
  logic det_raw, out_reg, out_next;
  logic [CNT_W-1:0] stab_reg, stab_next, filt_cyc;
  assign det_raw = (detect_mode_sel == VRS_HALL) ? cmp_s2_reg[3] : zc_reg;
  assign filt_cyc = (filt_reg == 2'h0) ? FILT_CYC_0 : (filt_reg == 2'h1) ? FILT_CYC_1 :
                    (filt_reg == 2'h2) ? FILT_CYC_2 : FILT_CYC_3;
  always_comb begin
    out_next = out_reg;
    stab_next = '0;
    if (det_raw != out_reg) begin
      stab_next = stab_reg + 1'b1;
      if (stab_reg > filt_cyc) begin
        out_next = det_raw;
        stab_next = '0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      stab_reg <= '0;
    end else begin
      out_reg <= out_next;
      stab_reg <= stab_next;
    end
  end
  assign sensor_pulse_out = out_reg;
  assign hall_ref_force = (detect_mode_sel == VRS_HALL);
  assign active_threshold_sel = eff_thr;
  assign active_time_sel = eff_time;

  // ----------------------------------------------------------------
  // Diagnosis
  // ----------------------------------------------------------------
  typedef enum logic {DG_IDLE, DG_CONV} vrs_dstate_t;
  vrs_dstate_t dst_reg, dst_next;
  vrs_diag_t dmode_reg, dmode_next;
  logic [CNT_W-1:0] conv_reg, conv_next;
  logic dv_sc_reg, dv_sc_next, dv_ol_reg, dv_ol_next, dv_m_reg, dv_m_next;
  logic sg_reg, sg_next, sb_reg, sb_next, ol_reg, ol_next;
  logic [ADC_W-1:0] mv_reg, mv_next;
  logic diag_en, start;
  assign diag_en = (detect_mode_sel != VRS_HALL) && (diag_mode_sel != VRS_DG_NONE);
  assign start = diag_start_cmd && diag_en && (dst_reg == DG_IDLE);
  always_comb begin
    dst_next = dst_reg;
    dmode_next = dmode_reg;
    conv_next = conv_reg;
    dv_sc_next = dv_sc_reg && !diag_result_a_read;
    dv_ol_next = dv_ol_reg && !diag_result_a_read;
    dv_m_next = dv_m_reg && !diag_result_b_read;
    {sg_next, sb_next, ol_next, mv_next} = {sg_reg, sb_reg, ol_reg, mv_reg};
    unique case (dst_reg)
      DG_IDLE: begin
        if (start) begin
          dst_next = DG_CONV;
          dmode_next = diag_mode_sel;
          conv_next = '0;
          if (diag_mode_sel == VRS_DG_SHORT) dv_sc_next = 1'b0;
          if (diag_mode_sel == VRS_DG_OPEN) dv_ol_next = 1'b0;
          if (diag_mode_sel == VRS_DG_MEAS) dv_m_next = 1'b0;
        end
      end
      DG_CONV: begin
        conv_next = conv_reg + 1'b1;
        if (detect_mode_sel == VRS_HALL) begin
          dst_next = DG_IDLE;
        end else if (conv_reg >= CONV_CYC - 1'b1) begin
          dst_next = DG_IDLE;
          unique case (dmode_reg)
            VRS_DG_SHORT: begin
              dv_sc_next = 1'b1;
              sg_next = cmp_s2_reg[2];
              sb_next = cmp_s2_reg[1];
            end
            VRS_DG_OPEN: begin
              dv_ol_next = 1'b1;
              ol_next = cmp_s2_reg[0];
            end
            default: begin
              dv_m_next = 1'b1;
              mv_next = samp_s2_reg;
            end
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dst_reg <= DG_IDLE;
      dmode_reg <= VRS_DG_NONE;
      conv_reg <= '0;
      {dv_sc_reg, dv_ol_reg, dv_m_reg, sg_reg, sb_reg, ol_reg} <= '0;
      mv_reg <= '0;
    end else begin
      dst_reg <= dst_next;
      dmode_reg <= dmode_next;
      conv_reg <= conv_next;
      {dv_sc_reg, dv_ol_reg, dv_m_reg} <= {dv_sc_next, dv_ol_next, dv_m_next};
      {sg_reg, sb_reg, ol_reg} <= {sg_next, sb_next, ol_next};
      mv_reg <= mv_next;
    end
  end
  // Sources while a diagnosis mode is active
  assign pullup_pos_en = diag_en;
  assign pulldown_neg_en = diag_en;
  assign diag_current_out = !diag_en ? 2'h0 : (diag_mode_sel == VRS_DG_SHORT) ? short_diag_current_sel :
                            (diag_mode_sel == VRS_DG_OPEN) ? openload_diag_current_sel : measure_diag_current_sel;
  assign short_diag_valid = dv_sc_reg;
  assign openload_diag_valid = dv_ol_reg;
  assign measure_diag_valid = dv_m_reg;
  assign short_ground_flag = sg_reg;
  assign short_battery_flag = sb_reg;
  assign open_load_flag = ol_reg;
  assign measured_voltage_value = mv_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  manual_only_cfg_a: assert property (cfg_write && auto_mode |=> $stable(thr_reg) && $stable(time_reg))
    else $error("threshold changed outside manual");
  out_filter_a: assert property ($changed(out_reg) |-> $past(stab_reg) > $past(filt_cyc))
    else $error("output changed before filter time");
  zc_armed_a: assert property ((detect_mode_sel != VRS_HALL) && $changed(zc_reg) |-> $past(armed_reg))
    else $error("crossing without armed peak");
  peak_time_a: assert property (!armed_reg && armed_next |-> above_reg > peak_cyc)
    else $error("peak armed too early");
  hall_no_diag_a: assert property (detect_mode_sel == VRS_HALL |-> !pullup_pos_en && !start)
    else $error("diagnosis active in hall mode");
  valid_read_a: assert property (diag_result_a_read && dst_reg == DG_IDLE |=> !short_diag_valid && !openload_diag_valid)
    else $error("valid not cleared by read");
  result_same_a: assert property ($rose(measure_diag_valid) |-> measured_voltage_value == $past(samp_s2_reg))
    else $error("measurement stale at valid");
  conv_done_a: assert property (start && diag_mode_sel == VRS_DG_SHORT && detect_mode_sel != VRS_HALL
    ##1 (detect_mode_sel != VRS_HALL && !diag_result_a_read) [*8] |-> ##[1:800] short_diag_valid)
    else $error("short diagnosis did not complete");
  cov_pulse_c: cover property ($rose(sensor_pulse_out));
  cov_meas_c: cover property ($rose(measure_diag_valid));
  cov_open_c: cover property ($rose(openload_diag_valid) && open_load_flag);
endmodule : vrs_detect

// File: pkg/vrs_pkg.sv
// Package: constants and types for the reluctance/Hall sensor detect block
package vrs_pkg;
  localparam int unsigned ADC_W = 10;
  localparam int unsigned CLK_MHZ = 100;
  // Peak thresholds in ADC counts (magnitude), selectable by host
  localparam logic [ADC_W-1:0] PEAK_THR_0 = 10'h0_00A;
  localparam logic [ADC_W-1:0] PEAK_THR_1 = 10'h0_01E;
  localparam logic [ADC_W-1:0] PEAK_THR_2 = 10'h0_046;
  localparam logic [ADC_W-1:0] PEAK_THR_3 = 10'h0_06E;
  // Minimum peak times in microseconds
  localparam int unsigned PEAK_TIME_0_US = 10;
  localparam int unsigned PEAK_TIME_1_US = 250;
  localparam int unsigned PEAK_CYC_0 = PEAK_TIME_0_US * CLK_MHZ;
  localparam int unsigned PEAK_CYC_1 = PEAK_TIME_1_US * CLK_MHZ;
  // Output filter times in microseconds
  localparam int unsigned FILT_US_0 = 1;
  localparam int unsigned FILT_US_1 = 2;
  localparam int unsigned FILT_US_2 = 4;
  localparam int unsigned FILT_US_3 = 8;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] FILT_CYC_0 = CNT_W'(FILT_US_0 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILT_CYC_1 = CNT_W'(FILT_US_1 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILT_CYC_2 = CNT_W'(FILT_US_2 * CLK_MHZ);
  localparam logic [CNT_W-1:0] FILT_CYC_3 = CNT_W'(FILT_US_3 * CLK_MHZ);
  // Diagnosis conversion time in microseconds
  localparam int unsigned CONV_US = 8;
  localparam logic [CNT_W-1:0] CONV_CYC = CNT_W'(CONV_US * CLK_MHZ);
  // Reset selections
  localparam logic [1:0] PEAK_THR_RST = 2'h0;
  localparam logic PEAK_TIME_RST = 1'b0;
  localparam logic [1:0] FILT_RST = 2'h0;
  // Speed split: half-period above this count selects the long peak time
  localparam logic [CNT_W-1:0] SLOW_HALF_CYC = 16'h2_710;
  typedef enum logic [1:0] {VRS_AUTO, VRS_MANUAL, VRS_SEMI, VRS_HALL} vrs_mode_t;
  typedef enum logic [1:0] {VRS_DG_SHORT, VRS_DG_OPEN, VRS_DG_MEAS, VRS_DG_NONE} vrs_diag_t;
endpackage : vrs_pkg

// File: verif/vrs_sensor_model.sv
// Sensor model: triangle-wave reluctance signal, steady level while idle
`timescale 1ns/1ps
module vrs_sensor_model #(
  parameter int QTR = 1500
) (
  input wire logic clk,
  input wire logic run,
  input wire logic signed [vrs_pkg::ADC_W-1:0] amp,
  input wire logic signed [vrs_pkg::ADC_W-1:0] level,
  output logic signed [vrs_pkg::ADC_W-1:0] sample
);
  import vrs_pkg::*;
  int ph = 0;
  int tri_v;
  // ----------------------------------------
  // Phase and waveform
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!run) begin
      ph <= 0;
    end else begin
      ph <= (ph + 1) % (4 * QTR);
    end
  end
  // Two zero crossings a period, one peak between each pair
  always_comb begin
    if (ph <= QTR) begin
      tri_v = ph;
    end else if (ph <= 3 * QTR) begin
      tri_v = 2 * QTR - ph;
    end else begin
      tri_v = ph - 4 * QTR;
    end
    sample = run ? ADC_W'(int'(amp) * tri_v / QTR) : level;
  end
endmodule : vrs_sensor_model

// File: verif/tb_top.sv
// Testbench: stimulus, reference checks and verdict for the sensor detect block
`timescale 1ns/1ps
module tb_top;
  import vrs_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int QTR = 1500;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic run = 1'b0, hall_in = 1'b0, sg = 1'b0, sb = 1'b0, ol = 1'b0, tsel = 1'b0;
  logic cfg_wr = 1'b0, start = 1'b0, rd_a = 1'b0, rd_b = 1'b0, p;
  logic [1:0] thr = 2'h0, fsel = 2'h0, cur_sc = 2'h0, cur_ol = 2'h0, cur_ms = 2'h0;
  logic signed [ADC_W-1:0] amp = '0, level = '0, sample;
  vrs_mode_t mode = VRS_MANUAL;
  vrs_diag_t dmode = VRS_DG_NONE;
  vrs_mode_t ms[3] = '{VRS_AUTO, VRS_SEMI, VRS_HALL};
  logic pulse, pu, pd, href, tsel_act, v_sc, v_ol, v_ms, f_sg, f_sb, f_ol;
  logic [1:0] cur, thr_act;
  logic [ADC_W-1:0] meas;
  logic q[$];
  int error_cnt = 0, n_tests = 0, cycles = 0, cnt = 0, seed = 32'h351e;
  int fcs[4] = '{FILT_US_0 * CLK_MHZ, FILT_US_1 * CLK_MHZ, FILT_US_2 * CLK_MHZ, FILT_US_3 * CLK_MHZ};

  vrs_detect i_vrs_detect (
    .clk(clk), .rst_n(rst_n), .sensor_diff_sample(sample), .hall_comp_in(hall_in),
    .short_ground_comp(sg), .short_battery_comp(sb), .open_load_comp(ol), .cfg_write(cfg_wr),
    .peak_threshold_sel(thr), .peak_time_sel(tsel), .output_filter_sel(fsel), .detect_mode_sel(mode),
    .diag_mode_sel(dmode), .short_diag_current_sel(cur_sc), .openload_diag_current_sel(cur_ol),
    .measure_diag_current_sel(cur_ms), .diag_start_cmd(start), .diag_result_a_read(rd_a),
    .diag_result_b_read(rd_b), .sensor_pulse_out(pulse), .pullup_pos_en(pu), .pulldown_neg_en(pd),
    .diag_current_out(cur), .hall_ref_force(href), .active_threshold_sel(thr_act),
    .active_time_sel(tsel_act), .short_diag_valid(v_sc), .openload_diag_valid(v_ol),
    .measure_diag_valid(v_ms), .short_ground_flag(f_sg), .short_battery_flag(f_sb),
    .open_load_flag(f_ol), .measured_voltage_value(meas)
  );
  vrs_sensor_model #(.QTR(QTR)) i_vrs_sensor_model (
    .clk(clk), .run(run), .amp(amp), .level(level), .sample(sample)
  );

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t: %s", $time, msg);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Mode settles a cycle before the field write
  task automatic cfg(input vrs_mode_t m, input logic [1:0] t, input logic ts, input logic [1:0] f);
    mode = m;
    cyc(1);
    thr = t;
    tsel = ts;
    fsel = f;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
  endtask : cfg
  function automatic logic valid_of(input int d);
    return d == 0 ? v_sc : (d == 1 ? v_ol : v_ms);
  endfunction : valid_of
  task automatic pulse_start();
    start = 1'b1;
    cyc(1);
    start = 1'b0;
  endtask : pulse_start
  // Reference: pulse level at each peak after skip alternates if tog is set, else holds
  task automatic vr_run(input int n, input int skip, input bit tog);
    run = 1'b1;
    cyc(QTR);
    q.delete();
    repeat (n) begin
      q.push_back(pulse);
      if (q.size() > skip) begin
        check(q[$] === (tog ? ~q[$ - 1] : q[$ - 1]), "pulse level at peak");
      end
      cyc(2 * QTR);
    end
    run = 1'b0;
  endtask : vr_run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(10);
    rst_n = 1'b1;
    check(thr_act === 2'h0 && tsel_act === 1'b0, "reset selections");
    check({v_sc, v_ol, v_ms, pulse} === 4'h0, "reset outputs");
    for (int k = 0; k < 4; k++) begin
      cfg(VRS_MANUAL, 2'(k), 1'(k), 2'h0);
      check(thr_act === 2'(k) && tsel_act === 1'(k), "manual selections");
    end
    for (int i = 0; i < 3; i++) begin
      cfg(ms[i], 2'h0, 1'b0, 2'h0);
      check(ms[i] != VRS_SEMI || thr_act === 2'h0, "semi threshold");
      mode = VRS_MANUAL;
      cyc(1);
      check(thr_act === 2'h3 && tsel_act === 1'b1, "write taken outside manual");
    end
    $display("test config done");
    for (int d = 0; d < 3; d++) begin
      dmode = vrs_diag_t'(d);
      {cur_sc, cur_ol, cur_ms} = 6'($random(seed));
      {sg, sb, ol} = 3'($random(seed));
      level = ADC_W'($random(seed));
      // Host lets the pins settle before starting
      cyc(20);
      check(pu === 1'b1 && pd === 1'b1, "diag sources");
      check(cur === (d == 0 ? cur_sc : (d == 1 ? cur_ol : cur_ms)), "diag current");
      start = 1'b1;
      cnt = 0;
      do begin
        cyc(1);
        start = 1'b0;
        cnt++;
      end while (valid_of(d) !== 1'b1 && cnt < 2000);
      check(cnt == int'(CONV_CYC) + 1, "diag latency");
      check(d != 0 || {f_sg, f_sb} === {sg, sb}, "short flags");
      check(d != 1 || f_ol === ol, "open-load flag");
      check(d != 2 || meas === level, "measured value");
      pulse_start();
      cyc(1);
      check(valid_of(d) === 1'b0, "valid kept on restart");
      cyc(int'(CONV_CYC));
      check(valid_of(d) === 1'b1, "restart not completed");
      rd_a = (d < 2);
      rd_b = (d == 2);
      cyc(1);
      rd_a = 1'b0;
      rd_b = 1'b0;
      cyc(1);
      check(valid_of(d) === 1'b0, "valid kept on read");
    end
    dmode = VRS_DG_NONE;
    cyc(1);
    check(pu === 1'b0 && pd === 1'b0, "sources without diag");
    $display("test diagnosis done");
    dmode = VRS_DG_SHORT;
    cfg(VRS_HALL, 2'h0, 1'b0, 2'h0);
    check(href === 1'b1 && pu === 1'b0 && pd === 1'b0, "hall setup");
    pulse_start();
    cyc(900);
    check({v_sc, v_ol, v_ms} === 3'h0, "start taken in hall");
    for (int f = 0; f < 4; f++) begin
      cfg(VRS_HALL, 2'h0, 1'b0, 2'(f));
      p = pulse;
      hall_in = ~hall_in;
      cyc(fcs[f] / 2);
      hall_in = ~hall_in;
      cyc(fcs[f] + 20);
      check(pulse === p, "glitch passed filter");
      hall_in = ~hall_in;
      cnt = 0;
      while (pulse === p && cnt < 2000) begin
        cyc(1);
        cnt++;
      end
      check(cnt > fcs[f] && cnt <= fcs[f] + 8, "filter delay");
    end
    $display("test hall done");
    dmode = VRS_DG_NONE;
    level = '0;
    cfg(VRS_MANUAL, 2'h0, 1'b0, 2'h0);
    amp = 10'h005;
    vr_run(3, 1, 1'b0);
    // Large enough that the adapted top threshold still leaves a valid peak time
    amp = 10'h1f0;
    // Configuration changes only while the inputs are quiet
    for (int i = 0; i < 3; i++) begin
      cfg(i == 0 ? VRS_MANUAL : ms[i - 1], 2'h0, 1'b0, 2'h0);
      vr_run(5, i == 0 ? 1 : 3, 1'b1);
    end
    $display("test reluctance done");
    report_and_stop();
  end
endmodule : tb_top
